// *** crs_map.vh ***
`ifndef CRS_MAP_VH
`define CRS_MAP_VH
// Condition flags bit positions.
`define CRS_CF_IMASK    7
`define CRS_CF_SPARE    6
`define CRS_CF_HALF     5
`define CRS_CF_USER     4
`define CRS_CF_NEG      3
`define CRS_CF_ZERO     2
`define CRS_CF_OVF      1
`define CRS_CF_CARRY    0
// Extended control bit positions.
`define CRS_XC_TRACE    7
`define CRS_XC_RSV_VAL  4'h0
// Reset values.
`define CRS_CF_RESET    8'h80
`define CRS_XC_RESET    8'h07
`define CRS_IP_RESET    24'h000000
`define CRS_GPR_RESET   32'h00000000
// Interrupt refusal after an extended control update, in states.
`define CRS_HOLD_STATES 2'h3
// Operand sizes.
`define CRS_SZ_BYTE     2'h0
`define CRS_SZ_WORD     2'h1
`define CRS_SZ_LONG     2'h2
// Control register write operations.
`define CRS_OP_LOAD     3'h0
`define CRS_OP_AND      3'h1
`define CRS_OP_OR       3'h2
`define CRS_OP_XOR      3'h3
`define CRS_OP_STORE    3'h4
`endif

// *** crs_register_set.v ***
`timescale 1ns/1ps
`include "crs_map.vh"

// Contract
// - Eight identical 32-bit general registers, accessible at 32, 16 or 8 bits.
// - Each 32-bit register splits into independent upper and lower 16-bit halves.
// - Each lower half splits into independent high and low byte registers.
// - A 24-bit instruction pointer whose lowest bit reads zero on fetch.
// - Extended control bit 7 set requests trace handling after each instruction.
// - Extended control bits 2 to 0 hold the interrupt mask level.
// - Non-store updates of extended control refuse all interrupts for 3 states.
// - Condition mask bit 7 set masks all interrupts except the non-maskable one.
// - Exception entry sets the condition mask bit to one.
// - Condition bit 6 is software writable and may act as an extra mask.
// - Byte arithmetic sets half-carry from carry or borrow out of bit 3.
// - Word arithmetic sets half-carry from carry or borrow out of bit 11.
// - Longword arithmetic sets half-carry from carry or borrow out of bit 27.
// - Condition bit 4 is a user bit writable by control instructions only.
// - Negative flag captures the sign bit of the result.
// - Zero flag is set for a zero result and cleared otherwise.
// - Overflow flag is set on arithmetic overflow and cleared otherwise.
// - Carry flag records add carry, subtract borrow or shifted-out bit.
// - Bit-manipulation instructions use the carry flag as bit accumulator.
// - Advanced mode addresses a full 16-megabyte space.
// - Normal mode restricts addressing to a 64-kilobyte space.
// - Normal mode drops the upper 8 bits of effective addresses.
module crs_register_set (
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        clk_en,
  input  wire        gpr_we,
  input  wire [2:0]  gpr_wsel,
  input  wire [1:0]  gpr_wsize,
  input  wire        gpr_wupper,
  input  wire        gpr_wbyte_hi,
  input  wire [31:0] gpr_wdata,
  input  wire [2:0]  gpr_rsel,
  input  wire [1:0]  gpr_rsize,
  input  wire        gpr_rupper,
  input  wire        gpr_rbyte_hi,
  output reg  [31:0] gpr_rdata,
  input  wire        ip_load,
  input  wire [23:0] ip_load_val,
  input  wire        ip_advance,
  output reg  [23:0] fetch_addr,
  input  wire        ctl_we,
  input  wire        ctl_sel_ext,
  input  wire [2:0]  ctl_op,
  input  wire [7:0]  ctl_wdata,
  output reg  [7:0]  condition_flags_reg,
  output reg  [7:0]  extended_control_reg,
  input  wire        alu_valid,
  input  wire [1:0]  alu_size,
  input  wire        alu_sub,
  input  wire        alu_half_en,
  input  wire        alu_shift,
  input  wire        alu_shift_out,
  input  wire [31:0] alu_a,
  input  wire [31:0] alu_b,
  input  wire [31:0] alu_result,
  input  wire        bit_acc_we,
  input  wire        bit_acc_val,
  output reg         bit_acc,
  input  wire        exc_start,
  input  wire        insn_done,
  input  wire        spare_as_mask,
  input  wire        advanced_mode,
  input  wire [31:0] ea_in,
  output reg  [23:0] ea_out,
  output reg         trace_req,
  output reg         irq_block,
  output reg         maskable_allowed,
  output reg  [2:0]  interrupt_level_mask
);

  // Register file view: one word per slot, driven from the slot flip-flops below.
  wire [31:0] wide_gpr_32 [0:7];
  genvar      g;

  // Control state, its next values and the interrupt refusal counter.
  reg  [23:0] ip_q;
  reg  [7:0]  cf_q;
  reg  [7:0]  xc_q;
  reg  [1:0]  hold_q;
  reg  [7:0]  cf_d;
  reg  [7:0]  xc_d;
  wire [23:0] ip_next;
  localparam [7:0] XC_RESET_V = `CRS_XC_RESET;

  // Control instruction decode.
  reg  [7:0]  ctl_cur;
  reg  [7:0]  ctl_new;
  wire        ctl_mod_cf;
  wire        ctl_mod_xc;

  // Read path selection.
  reg  [31:0] rd_word;
  reg  [15:0] rd_half;
  reg  [7:0]  rd_byte;

  // Arithmetic flag helpers.
  reg         msb_r;
  reg         msb_a;
  reg         msb_b;
  reg         hc;
  reg         cy;
  reg         zr;
  reg  [31:0] b_eff;
  reg  [32:0] sum_full;
  reg  [28:0] sum_27;
  reg  [12:0] sum_11;
  reg  [4:0]  sum_3;

  // Each slot is one 32-bit flip-flop word that takes a full, half or byte write.
  // A narrow write leaves every other bit of the word untouched, so the halves and
  // the two low bytes behave as independent registers of their own.
  generate
    for (g = 0; g < 8; g = g + 1) begin : gpr_slot
      reg [31:0] word_q;

      always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          word_q <= `CRS_GPR_RESET;
        end else if (clk_en && gpr_we && gpr_wsel == g) begin
          case (gpr_wsize)
            `CRS_SZ_LONG: word_q <= gpr_wdata;
            `CRS_SZ_WORD: begin
              if (gpr_wupper) begin
                word_q[31:16] <= gpr_wdata[15:0];
              end else begin
                word_q[15:0] <= gpr_wdata[15:0];
              end
            end
            `CRS_SZ_BYTE: begin
              if (gpr_wbyte_hi) begin
                word_q[15:8] <= gpr_wdata[7:0];
              end else begin
                word_q[7:0] <= gpr_wdata[7:0];
              end
            end
            default: word_q <= word_q;
          endcase
        end
      end

      // The read mux sees every slot through this indexed view.
      assign wide_gpr_32[g] = word_q;
    end
  endgenerate

  // Read-side selection of the word, half or byte view, zero extended.
  // The byte view only reaches the low half, matching how byte registers are laid out.
  always @* begin
    rd_word = wide_gpr_32[gpr_rsel];
    rd_half = gpr_rupper ? rd_word[31:16] : rd_word[15:0];
    rd_byte = gpr_rbyte_hi ? rd_word[15:8] : rd_word[7:0];
  end

  // Registered read port; the data appears one edge after the selection is set.
  // Size code 3 is unused and reads as zero rather than as a stale word.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      gpr_rdata <= 32'h00000000;
    end else if (clk_en) begin
      case (gpr_rsize)
        `CRS_SZ_LONG: gpr_rdata <= rd_word;
        `CRS_SZ_WORD: gpr_rdata <= {16'h0000, rd_half};
        `CRS_SZ_BYTE: gpr_rdata <= {24'h000000, rd_byte};
        default:      gpr_rdata <= 32'h00000000;
      endcase
    end
  end

  // Instruction pointer steps by one instruction word. The stored pointer keeps an
  // odd load value as written, but the fetch address always has its lowest bit
  // cleared, so a stray odd jump target can never produce a misaligned fetch.
  assign ip_next = ip_q + 24'h000002;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ip_q       <= `CRS_IP_RESET;
      fetch_addr <= `CRS_IP_RESET;
    end else if (clk_en) begin
      if (ip_load) begin
        ip_q       <= ip_load_val;
        fetch_addr <= {ip_load_val[23:1], 1'b0};
      end else if (ip_advance) begin
        ip_q       <= ip_next;
        fetch_addr <= {ip_next[23:1], 1'b0};
      end
    end
  end

  // Arithmetic helpers: carries at bits 3, 11, 27 and at the top of each size.
  // Subtraction is done as a plus the inverted b plus one, so every carry here is
  // the inverse of the borrow; the flag logic flips it back with alu_sub. The carry
  // into a size boundary is recovered from the full sum by xor with both operands.
  always @* begin
    b_eff    = alu_sub ? ~alu_b : alu_b;
    sum_full = {1'b0, alu_a} + {1'b0, b_eff} + {32'h00000000, alu_sub};
    sum_27   = {1'b0, alu_a[27:0]} + {1'b0, b_eff[27:0]} + {28'h0000000, alu_sub};
    sum_11   = {1'b0, alu_a[11:0]} + {1'b0, b_eff[11:0]} + {12'h000, alu_sub};
    sum_3    = {1'b0, alu_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, alu_sub};
    case (alu_size)
      `CRS_SZ_BYTE: begin
        hc    = sum_3[4] ^ alu_sub;
        msb_r = alu_result[7];
        msb_a = alu_a[7];
        msb_b = b_eff[7];
        zr    = (alu_result[7:0] == 8'h00);
        cy    = alu_a[8] ^ b_eff[8] ^ sum_full[8] ^ alu_sub;
      end
      `CRS_SZ_WORD: begin
        hc    = sum_11[12] ^ alu_sub;
        msb_r = alu_result[15];
        msb_a = alu_a[15];
        msb_b = b_eff[15];
        zr    = (alu_result[15:0] == 16'h0000);
        cy    = alu_a[16] ^ b_eff[16] ^ sum_full[16] ^ alu_sub;
      end
      default: begin
        hc    = sum_27[28] ^ alu_sub;
        msb_r = alu_result[31];
        msb_a = alu_a[31];
        msb_b = b_eff[31];
        zr    = (alu_result == 32'h00000000);
        cy    = sum_full[32] ^ alu_sub;
      end
    endcase
  end

  // Control-register operand and the logical combine of load, and, or, xor.
  // Store and unused codes return the current value so that nothing changes.
  always @* begin
    ctl_cur = ctl_sel_ext ? xc_q : cf_q;
    case (ctl_op)
      `CRS_OP_LOAD: ctl_new = ctl_wdata;
      `CRS_OP_AND:  ctl_new = ctl_cur & ctl_wdata;
      `CRS_OP_OR:   ctl_new = ctl_cur | ctl_wdata;
      `CRS_OP_XOR:  ctl_new = ctl_cur ^ ctl_wdata;
      default:      ctl_new = ctl_cur;
    endcase
  end

  // Only load, and, or and xor change a control register; store and the unused
  // codes leave it alone and must not open the interrupt refusal window either.
  assign ctl_mod_cf = ctl_we && !ctl_sel_ext && (ctl_op <= `CRS_OP_XOR);
  assign ctl_mod_xc = ctl_we && ctl_sel_ext && (ctl_op <= `CRS_OP_XOR);

  // Next condition flags and extended control values. Later assignments win, so the
  // priority is: control write, then arithmetic flags, then the bit accumulator,
  // and finally exception entry, which always leaves the mask bit set.
  always @* begin
    cf_d = cf_q;
    xc_d = xc_q;
    if (ctl_mod_cf) begin
      cf_d = ctl_new;
    end
    if (ctl_mod_xc) begin
      xc_d = {ctl_new[`CRS_XC_TRACE], `CRS_XC_RSV_VAL, ctl_new[2:0]};
    end
    if (alu_valid) begin
      cf_d[`CRS_CF_NEG]  = msb_r;
      cf_d[`CRS_CF_ZERO] = zr;
      cf_d[`CRS_CF_OVF]  = (msb_a == msb_b) && (msb_r != msb_a);
      cf_d[`CRS_CF_CARRY] = alu_shift ? alu_shift_out : cy;
      if (alu_half_en) begin
        cf_d[`CRS_CF_HALF] = hc;
      end
    end
    if (bit_acc_we) begin
      cf_d[`CRS_CF_CARRY] = bit_acc_val;
    end
    if (exc_start) begin
      cf_d[`CRS_CF_IMASK] = 1'b1;
    end
  end

  // Flag registers and their mirrored outputs. The ports carry the same value as the
  // internal copies, so a read never lags a write by more than the one edge.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cf_q                 <= `CRS_CF_RESET;
      xc_q                 <= `CRS_XC_RESET;
      condition_flags_reg  <= `CRS_CF_RESET;
      extended_control_reg <= `CRS_XC_RESET;
      interrupt_level_mask <= XC_RESET_V[2:0];
      bit_acc              <= 1'b0;
    end else if (clk_en) begin
      cf_q                 <= cf_d;
      xc_q                 <= xc_d;
      condition_flags_reg  <= cf_d;
      extended_control_reg <= xc_d;
      interrupt_level_mask <= xc_d[2:0];
      bit_acc              <= cf_d[`CRS_CF_CARRY];
    end
  end

  // Interrupt refusal window. A modifying extended control write reloads the counter, so the block
  // stays up for three states after the last such write, not after the first.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_q    <= 2'h0;
      irq_block <= 1'b0;
    end else if (clk_en) begin
      if (ctl_mod_xc) begin
        hold_q    <= `CRS_HOLD_STATES;
        irq_block <= 1'b1;
      end else if (hold_q != 2'h0) begin
        hold_q    <= hold_q - 2'h1;
        irq_block <= (hold_q != 2'h1);
      end else begin
        irq_block <= 1'b0;
      end
    end
  end

  // Trace request and maskable-interrupt permission. The trace bit is taken as it
  // stood before the finishing edge, so a write in that cycle affects the next one.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      trace_req        <= 1'b0;
      maskable_allowed <= 1'b0;
    end else if (clk_en) begin
      trace_req        <= insn_done && xc_q[`CRS_XC_TRACE];
      maskable_allowed <= !cf_d[`CRS_CF_IMASK] &&
                          !(spare_as_mask && cf_d[`CRS_CF_SPARE]);
    end
  end

  // Effective address: full 24 bits in advanced mode, low 16 bits in normal mode.
  // Normal mode clears the upper byte, folding every address into the low 64 kilobytes.
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ea_out <= 24'h000000;
    end else if (clk_en) begin
      if (advanced_mode) begin
        ea_out <= ea_in[23:0];
      end else begin
        ea_out <= {8'h00, ea_in[15:0]};
      end
    end
  end

endmodule // crs_register_set

// *** crs_register_set_assertions.sv ***
`timescale 1ns/1ps
// Checks port timing of the register set.
module crs_rs_chk (
  input wire        sys_clk,
  input wire        arst_n,
  input wire        clk_en,
  input wire        ip_load,
  input wire        ip_advance,
  input wire [23:0] ip_load_val,
  input wire [23:0] fetch_addr,
  input wire        ctl_we,
  input wire        ctl_sel_ext,
  input wire [2:0]  ctl_op,
  input wire [7:0]  ctl_wdata,
  input wire [7:0]  extended_control_reg,
  input wire [7:0]  condition_flags_reg,
  input wire        irq_block,
  input wire        insn_done,
  input wire        trace_req,
  input wire        exc_start,
  input wire        advanced_mode,
  input wire [31:0] ea_in,
  input wire [23:0] ea_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // A non-store extended control update, then three cycles with no control writes.
  sequence s_upd;
    clk_en && ctl_we && ctl_sel_ext && ctl_op < 3'h4;
  endsequence
  sequence s_quiet;
    !ctl_we [*3];
  endsequence
  a_fetch_even: assert property (
    clk_en && ip_load && !ip_advance |=> fetch_addr == ($past(ip_load_val) & 24'hfffffe))
    else $error("fetch address wrong");
  a_ext_load: assert property (
    clk_en && ctl_we && ctl_sel_ext && ctl_op == 3'h0 |=> extended_control_reg == ($past(ctl_wdata) & 8'h87))
    else $error("extended control wrong");
  a_irq_hold: assert property (s_upd |=> irq_block [*3])
    else $error("irq block too short");
  a_irq_free: assert property (s_upd ##1 s_quiet |=> !irq_block)
    else $error("irq block too long");
  a_trace_on: assert property (
    clk_en && insn_done && extended_control_reg[7] |=> trace_req)
    else $error("trace request missing");
  a_exc_mask: assert property (clk_en && exc_start |=> condition_flags_reg[7])
    else $error("mask bit not set");
  a_ea_norm: assert property (
    clk_en && !advanced_mode |=> ea_out == ($past(ea_in) & 32'h0000ffff))
    else $error("normal address wrong");
  a_ea_adv: assert property (
    clk_en && advanced_mode |=> ea_out == ($past(ea_in) & 32'h00ffffff))
    else $error("advanced address wrong");
endmodule // crs_rs_chk

// *** crs_register_set_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the register set.
module crs_register_set_tb;
  reg         sys_clk, arst_n, clk_en, gpr_we, gpr_wupper, gpr_wbyte_hi, gpr_rupper, gpr_rbyte_hi;
  reg         ip_load, ip_advance, ctl_we, ctl_sel_ext, alu_valid, alu_sub, alu_half_en, alu_shift;
  reg         alu_shift_out, bit_acc_we, bit_acc_val, exc_start, insn_done, spare_as_mask, advanced_mode;
  reg         sb;
  reg  [2:0]  gpr_wsel, gpr_rsel, ctl_op;
  reg  [1:0]  gpr_wsize, gpr_rsize, alu_size;
  reg  [31:0] gpr_wdata, alu_a, alu_b, alu_result, ea_in, av, bv, rv;
  reg  [23:0] ip_load_val;
  reg  [7:0]  ctl_wdata;
  wire [31:0] gpr_rdata;
  wire [23:0] fetch_addr, ea_out;
  wire [7:0]  condition_flags_reg, extended_control_reg;
  wire [2:0]  interrupt_level_mask;
  wire        bit_acc, trace_req, irq_block, maskable_allowed;
  wire [4:0]  fl = {condition_flags_reg[5], condition_flags_reg[3:0]};
  integer     miscompares, n_tests, i, j;

  crs_register_set uut (.*);

  // Clock at 40 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Compares one value and counts it.
  task chk(input [39:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask

  // Waits one edge and lets its updates land.
  task nx;
    begin
      @(posedge sys_clk);
      #1;
    end
  endtask

  // Raises the chosen strobes for exactly one edge.
  task p(input [7:0] w);
    begin
      @(posedge sys_clk);
      {gpr_we, ctl_we, ip_load, ip_advance, exc_start, insn_done, bit_acc_we, alu_valid} <= w;
      @(posedge sys_clk);
      {gpr_we, ctl_we, ip_load, ip_advance, exc_start, insn_done, bit_acc_we, alu_valid} <= 8'h00;
      #1;
    end
  endtask

  // Register access tasks.
  task gw(input [2:0] s, input [1:0] z, input u, input h, input [31:0] d);
    begin
      {gpr_wsel, gpr_wsize, gpr_wupper, gpr_wbyte_hi, gpr_wdata} <= {s, z, u, h, d};
      p(8'h80);
    end
  endtask
  task gr(input [2:0] s, input [1:0] z, input u, input h, input [31:0] e);
    begin
      {gpr_rsel, gpr_rsize, gpr_rupper, gpr_rbyte_hi} <= {s, z, u, h};
      nx;
      chk("gpr", e, gpr_rdata);
    end
  endtask
  task ctl(input x, input [2:0] o, input [7:0] d);
    begin
      {ctl_sel_ext, ctl_op, ctl_wdata} <= {x, o, d};
      p(8'h40);
    end
  endtask
  task alu(input [1:0] z, input s, input [31:0] a, input [31:0] b, input [31:0] r, input sh);
    begin
      {alu_size, alu_sub, alu_a, alu_b, alu_result, alu_shift, alu_shift_out} <= {z, s, a, b, r, sh, sh};
      p(8'h01);
    end
  endtask

  // Expected half-carry, negative, zero, overflow and carry.
  function [4:0] flg(input [1:0] z, input s, input [31:0] a, input [31:0] b, input [31:0] r);
    integer w;
    reg [32:0] m, hm;
    begin
      w = (z == 2'h0) ? 8 : (z == 2'h1) ? 16 : 32;
      m = (33'h1 << w) - 33'h1;
      hm = (33'h1 << (w - 4)) - 33'h1;
      flg[4] = s ? (a & hm) < (b & hm) : (a & hm) + (b & hm) > hm;
      flg[3] = r[w-1];
      flg[2] = (r & m) == 0;
      flg[1] = (a[w-1] == (b[w-1] ^ s)) && (r[w-1] != a[w-1]);
      flg[0] = s ? (a & m) < (b & m) : (a & m) + (b & m) > m;
    end
  endfunction

  // Prints the counts and the verdict, then stops.
  task final_report;
    begin
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares = miscompares + 1;
    final_report;
  end

  // Main sequence.
  initial begin
    {gpr_we, gpr_wupper, gpr_wbyte_hi, gpr_rupper, gpr_rbyte_hi, ip_load, ip_advance, ctl_we} = '0;
    {ctl_sel_ext, alu_valid, alu_sub, alu_shift, alu_shift_out, bit_acc_we, bit_acc_val} = '0;
    {exc_start, insn_done, spare_as_mask, advanced_mode, gpr_wsel, gpr_rsel, ctl_op} = '0;
    {gpr_wsize, gpr_rsize, alu_size, gpr_wdata, alu_a, alu_b, alu_result, ea_in} = '0;
    {ip_load_val, ctl_wdata, arst_n, clk_en, alu_half_en} = {32'h0, 3'h3};
    {arst_n, miscompares, n_tests} = '0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    chk("xc", 32'h07, extended_control_reg);
    chk("lvl", 32'h7, interrupt_level_mask);
    chk("cf", 32'h80, condition_flags_reg);
    chk("pc", 32'h0, fetch_addr);
    for (i = 0; i < 8; i = i + 1) gw(i[2:0], 2'h2, 1'b0, 1'b0, 32'h01010101 * i + 32'h10203040);
    for (i = 0; i < 8; i = i + 1) gr(i[2:0], 2'h2, 1'b0, 1'b0, 32'h01010101 * i + 32'h10203040);
    gw(3'h3, 2'h1, 1'b1, 1'b0, 32'haaaa);
    gw(3'h3, 2'h0, 1'b0, 1'b1, 32'h55);
    gr(3'h3, 2'h2, 1'b0, 1'b0, 32'haaaa5543);
    gr(3'h3, 2'h1, 1'b1, 1'b0, 32'haaaa);
    gr(3'h3, 2'h1, 1'b0, 1'b0, 32'h5543);
    gr(3'h3, 2'h0, 1'b0, 1'b1, 32'h55);
    gr(3'h3, 2'h0, 1'b0, 1'b0, 32'h43);
    clk_en <= 1'b0;
    gw(3'h0, 2'h2, 1'b0, 1'b0, 32'hffffffff);
    clk_en <= 1'b1;
    gr(3'h0, 2'h2, 1'b0, 1'b0, 32'h10203040);
    $display("test registers done");
    ip_load_val <= 24'h123457;
    p(8'h20);
    chk("pc", 32'h123456, fetch_addr);
    p(8'h10);
    chk("pc", 32'h123458, fetch_addr);
    ctl(1'b1, 3'h0, 8'hff);
    chk("xc", 32'h87, extended_control_reg);
    chk("blk", 32'h1, irq_block);
    repeat (3) nx;
    chk("blk", 32'h0, irq_block);
    ctl(1'b1, 3'h4, 8'h00);
    chk("xc", 32'h87, extended_control_reg);
    chk("blk", 32'h0, irq_block);
    ctl(1'b1, 3'h5, 8'h00);
    chk("xc", 32'h87, extended_control_reg);
    chk("blk", 32'h0, irq_block);
    ctl(1'b1, 3'h0, 8'h80);
    p(8'h04);
    chk("trc", 32'h1, trace_req);
    ctl(1'b1, 3'h0, 8'h00);
    p(8'h04);
    chk("trc", 32'h0, trace_req);
    chk("lvl", 32'h0, interrupt_level_mask);
    ctl(1'b0, 3'h0, 8'h50);
    chk("cf", 32'h50, condition_flags_reg);
    ctl(1'b0, 3'h1, 8'h10);
    chk("cf", 32'h10, condition_flags_reg);
    ctl(1'b0, 3'h2, 8'h40);
    chk("cf", 32'h50, condition_flags_reg);
    ctl(1'b0, 3'h3, 8'h50);
    chk("cf", 32'h00, condition_flags_reg);
    nx;
    chk("ok", 32'h1, maskable_allowed);
    p(8'h08);
    chk("cf", 32'h80, condition_flags_reg);
    nx;
    chk("ok", 32'h0, maskable_allowed);
    spare_as_mask <= 1'b1;
    ctl(1'b0, 3'h0, 8'h40);
    nx;
    chk("ok", 32'h0, maskable_allowed);
    $display("test control done");
    bit_acc_val <= 1'b1;
    p(8'h02);
    chk("acc", 32'h1, bit_acc);
    chk("c", 32'h1, condition_flags_reg[0]);
    for (i = 0; i < 3; i = i + 1)
      for (j = 0; j < 4; j = j + 1) begin
        av = (j == 0) ? 32'h08080808 : (j == 1) ? 32'h88888888 : (j == 2) ? 32'h0 : 32'h5a5a5a5a;
        bv = (j == 2) ? 32'h1 : av;
        sb = j >= 2;
        rv = sb ? av - bv : av + bv;
        alu(i[1:0], sb, av, bv, rv, 1'b0);
        chk("flag", flg(i[1:0], sb, av, bv, rv), fl);
      end
    alu(2'h0, 1'b0, 32'h0, 32'h0, 32'h0, 1'b1);
    chk("c", 32'h1, condition_flags_reg[0]);
    $display("test flags done");
    ea_in <= 32'hdeadbeef;
    nx;
    chk("ea", 32'h00beef, ea_out);
    advanced_mode <= 1'b1;
    nx;
    chk("ea", 32'hadbeef, ea_out);
    $display("test address done");
    final_report;
  end
endmodule // crs_register_set_tb

bind crs_register_set crs_rs_chk u_chk (.*);
